//--- logic/bus_master.sv
// master end of the shared 36-line address/data bus
`timescale 1ns/1ps
module bus_master import mb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_pcie,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  // host answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_timeout,
  // configuration
  input wire logic bus_enable,
  output logic [31:0] timeout_count,
  // shared bus lines
  // thirty-six shared lines
  input wire logic [DATA_W-1:0] ad_in,
  output logic [DATA_W-1:0] ad_out,
  output logic ad_oe,
  output logic ale,
  output logic rd,
  output logic wr,
  output logic strobe_oe,
  input wire logic done_in
);
  mst_state_t state_r, state_nxt;
  logic [DATA_W-1:0] ad_s1_r, ad_s2_r;
  logic done_s1_r, done_s2_r;
  logic [ADDR_W-1:0] cmd_addr_r, last_addr_r;
  logic [DATA_W-1:0] cmd_wdata_r;
  logic cmd_write_r, cmd_pcie_r, addr_known_r;
  logic req_ready_r, rsp_valid_r, rsp_timeout_r;
  logic [DATA_W-1:0] rsp_rdata_r, ad_out_r;
  logic ad_oe_r, ale_r, rd_r, wr_r, strobe_oe_r;
  logic [31:0] timeout_count_r;
  logic accept, done_seen, timed_out;
  wd_if wd_bus ();

  answer_watchdog u_wd (
    .clk(clk),
    .reset(reset),
    .wd(wd_bus.tmr)
  );

  // lines come from off chip, so data and done share one two-stage path
  // common clock sampling
  always_ff @(posedge clk) begin
    ad_s1_r <= ad_in;
    ad_s2_r <= ad_s1_r;
    done_s1_r <= reset ? 1'b0 : done_in;
    done_s2_r <= reset ? 1'b0 : done_s1_r;
  end

  // wait-state decodes; done beats expiry when both land in one cycle
  assign accept = req_valid && req_ready_r;
  assign done_seen = (state_r == ST_WAIT) && done_s2_r;
  assign timed_out = (state_r == ST_WAIT) && !done_s2_r && wd_bus.expired;
  assign wd_bus.restart = (state_r == ST_STROBE);
  assign wd_bus.running = (state_r == ST_WAIT);

  // sequencer: repeat addresses skip the latch cycle
  // transfers start only from a host request
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept && !bus_enable) begin
          state_nxt = ST_RESP;
        end else if (accept && addr_known_r && req_addr == last_addr_r) begin
          state_nxt = ST_STROBE;
        end else if (accept) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: state_nxt = ST_STROBE;
      ST_STROBE: state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (done_seen || timed_out) begin
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: state_nxt = ST_IDLE;
    endcase
  end

  // state register, back to rest on reset
  always_ff @(posedge clk) begin
    state_r <= reset ? ST_IDLE : state_nxt;
  end

  // request capture; the enable is sampled once per request
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_addr_r <= '0;
      cmd_wdata_r <= '0;
      cmd_write_r <= 1'b0;
      cmd_pcie_r <= 1'b0;
    end else if (accept) begin
      cmd_addr_r <= req_addr;
      cmd_wdata_r <= req_wdata;
      cmd_write_r <= req_write;
      cmd_pcie_r <= req_pcie;
    end
  end

  // mirror of the slaves' address register
  // latched address stays current
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_known_r <= 1'b0;
      last_addr_r <= '0;
    end else if (state_r == ST_ADDR) begin
      addr_known_r <= 1'b1;
      last_addr_r <= cmd_addr_r;
    end
  end

  // bus drive; reads release the lines in the strobe cycle for turnaround
  // address, strobes and data drive
  always_ff @(posedge clk) begin
    if (reset) begin
      ale_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      ad_oe_r <= 1'b0;
      ad_out_r <= '0;
    end else begin
      ale_r <= (state_nxt == ST_ADDR);
      rd_r <= (state_nxt == ST_STROBE) && !(accept ? req_write : cmd_write_r);
      wr_r <= (state_nxt == ST_STROBE) && (accept ? req_write : cmd_write_r);
      ad_oe_r <= (state_nxt == ST_ADDR) || (state_nxt == ST_STROBE && wr_r == 1'b0 &&
                 (accept ? req_write : cmd_write_r));
      ad_out_r <= (state_nxt == ST_ADDR) ? (accept ? req_addr : cmd_addr_r)
                                        : (accept ? req_wdata : cmd_wdata_r);
    end
  end

  // strobes float while disabled so the lines stay free for other use
  // lines left free when off
  always_ff @(posedge clk) begin
    strobe_oe_r <= reset ? 1'b0 : bus_enable;
  end

  // host answer, one cycle per request
  // data taken on done
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_r <= 1'b0;
      rsp_timeout_r <= 1'b0;
      rsp_rdata_r <= '0;
    end else begin
      rsp_valid_r <= (state_nxt == ST_RESP);
      if (state_r == ST_IDLE && accept && !bus_enable) begin
        rsp_timeout_r <= 1'b0;
        rsp_rdata_r <= req_write ? WRITE_RSP_WORD : DISABLED_WORD;
      end else if (done_seen) begin
        rsp_timeout_r <= 1'b0;
        rsp_rdata_r <= cmd_write_r ? WRITE_RSP_WORD : ad_s2_r;
      end else if (timed_out) begin
        rsp_timeout_r <= 1'b1;
        rsp_rdata_r <= cmd_write_r ? WRITE_RSP_WORD
                     : (cmd_pcie_r ? PCIE_TIMEOUT_WORD : USB_TIMEOUT_WORD);
      end
    end
  end

  // only usb read timeouts are counted; wraps silently at the top
  // timeout counter bump
  always_ff @(posedge clk) begin
    if (reset) begin
      timeout_count_r <= COUNT_RESET;
    end else if (timed_out && !cmd_write_r && !cmd_pcie_r) begin
      timeout_count_r <= timeout_count_r + COUNT_STEP;
    end
  end

  // ready again as the sequencer returns to rest
  always_ff @(posedge clk) begin
    req_ready_r <= reset ? 1'b0 : (state_nxt == ST_IDLE);
  end

  // every output straight from its flop
  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign rsp_timeout = rsp_timeout_r;
  assign timeout_count = timeout_count_r;
  assign ad_out = ad_out_r;
  assign ad_oe = ad_oe_r;
  assign ale = ale_r;
  assign rd = rd_r;
  assign wr = wr_r;
  assign strobe_oe = strobe_oe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  disabled_read_a: assert property (
    state_r == ST_IDLE && accept && !bus_enable && !req_write
    |=> rsp_valid_r && rsp_rdata_r == DISABLED_WORD && !ale_r && !rd_r)
    else $error("disabled read did not return the disabled word");
  off_quiet_a: assert property (
    !bus_enable ##1 !bus_enable |-> !strobe_oe_r)
    else $error("strobes driven while the bus is disabled");
  latch_then_strobe_a: assert property (
    ale_r |=> (rd_r || wr_r) && !ale_r)
    else $error("address latch not followed by a strobe");
  read_capture_a: assert property (
    done_seen && !cmd_write_r |=> rsp_valid_r && rsp_rdata_r == $past(ad_s2_r) && !rsp_timeout_r)
    else $error("read data not taken on the done cycle");
  pcie_sentinel_a: assert property (
    timed_out && !cmd_write_r && cmd_pcie_r |=> rsp_rdata_r == PCIE_TIMEOUT_WORD && rsp_timeout_r)
    else $error("pcie timeout sentinel wrong");
  usb_count_a: assert property (
    timed_out && !cmd_write_r && !cmd_pcie_r
    |=> rsp_rdata_r == USB_TIMEOUT_WORD && timeout_count_r == $past(timeout_count_r) + COUNT_STEP)
    else $error("usb timeout sentinel or count wrong");
  answer_bound_a: assert property (
    (rd_r || wr_r) |-> ##[2:262] rsp_valid_r)
    else $error("transfer not closed within the window");
  no_early_timeout_a: assert property (
    rsp_valid_r && rsp_timeout_r |-> $past(wd_bus.count) == WD_LIMIT)
    else $error("timeout raised before the window ran out");
  write_drive_a: assert property (
    wr_r |-> ad_oe_r && ad_out_r == cmd_wdata_r && strobe_oe_r)
    else $error("write data not on the lines with the strobe");
  read_release_a: assert property (
    rd_r |-> !ad_oe_r ##1 !ad_oe_r)
    else $error("lines still driven during a read");
  addr_drive_a: assert property (
    ale_r |-> ad_oe_r && ad_out_r == cmd_addr_r)
    else $error("address not on the lines with the latch");

  read_ok_c: cover property (done_seen && !cmd_write_r);
  write_ok_c: cover property (done_seen && cmd_write_r);
  usb_timeout_c: cover property (timed_out && !cmd_pcie_r && !cmd_write_r);
  reuse_addr_c: cover property (state_r == ST_IDLE && accept && state_nxt == ST_STROBE);
endmodule

//--- logic/mb_pkg.sv
// shared constants and types for the shared-bus master
package mb_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // sentinel words handed back to the host
  localparam logic [31:0] PCIE_TIMEOUT_WORD = 32'hABCDABCD;
  localparam logic [31:0] USB_TIMEOUT_WORD = 32'hDEADDEAD;
  localparam logic [31:0] DISABLED_WORD = 32'h12345678;
  localparam logic [31:0] NO_REG_WORD = 32'hDEAD5566;
  localparam logic [31:0] WRITE_RSP_WORD = 32'h00000000;
  // bus clock and answer window
  localparam int BUS_CLOCK_MHZ = 48;
  localparam int BUS_WINDOW_CYCLES = 256;
  localparam int SYNC_STAGES = 2;
  localparam int WAIT_LIMIT = BUS_WINDOW_CYCLES + SYNC_STAGES;
  localparam int WD_W = 9;
  localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(WAIT_LIMIT);
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_STEP = 32'h00000001;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_WAIT, ST_RESP} mst_state_t;
endpackage

//--- logic/wd_if.sv
// handshake between the master sequencer and its answer watchdog
`timescale 1ns/1ps
interface wd_if import mb_pkg::*;;
  logic restart;
  logic running;
  logic expired;
  logic [WD_W-1:0] count;
  modport ctl (output restart, output running, input expired, input count);
  modport tmr (input restart, input running, output expired, output count);
endinterface

//--- logic/answer_watchdog.sv
// counts wait cycles and flags when the answer window has run out
`timescale 1ns/1ps
module answer_watchdog import mb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control from the sequencer
  wd_if.tmr wd
);
  logic [WD_W-1:0] cnt_r;
  logic expired_r;

  // counter saturates so a stuck sequencer cannot wrap it
  always_ff @(posedge clk) begin
    if (reset || wd.restart) begin
      cnt_r <= '0;
    end else if (wd.running && cnt_r != WD_LIMIT) begin
      cnt_r <= cnt_r + WD_W'(1);
    end
  end

  // expiry flag rises in the same cycle as the count reaches the limit
  // window run out
  always_ff @(posedge clk) begin
    if (reset || wd.restart) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= wd.running && (cnt_r == WD_LIMIT - WD_W'(1));
    end
  end

  assign wd.count = cnt_r;
  assign wd.expired = expired_r;

  count_bound_a: assert property (@(posedge clk) disable iff (reset) cnt_r <= WD_LIMIT)
    else $error("watchdog count passed its limit");
endmodule

//--- verif/mb_slave_model.sv
// behavioural slave standing at the far end of the shared bus
`timescale 1ns/1ps
module mb_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // resolved bus lines
  input wire logic [31:0] ad_in,
  input wire logic ale,
  input wire logic rd,
  input wire logic wr,
  // answer control
  input wire logic [8:0] lat,
  input wire logic mute,
  // slave drive
  output logic [31:0] ad_o,
  output logic done_o,
  output logic done_oe
);
  logic [31:0] addr_r;
  logic [31:0] mem_r [4];
  logic [8:0] cnt_r;
  logic pend_r;
  logic own;
  logic hit;
  // top nibble zero is ours, four words mapped
  assign own = addr_r[31:28] == 4'h0;
  assign hit = own && addr_r[27:0] < 28'h4;
  // one process: the answer depends on latch, strobe and countdown together
  always @(posedge clk) begin
    done_o <= 1'b0;
    // done parked low one cycle before release
    done_oe <= done_o;
    ad_o <= ~ad_o; // lines not held keep changing
    if (ale) begin
      addr_r <= ad_in;
    end
    // write data taken in the strobe cycle
    if (rd || wr) begin
      if (wr && hit) begin
        mem_r[addr_r[1:0]] <= ad_in;
      end
      pend_r <= 1'b1;
      cnt_r <= lat;
    end else if (pend_r && cnt_r != 9'h0) begin
      cnt_r <= cnt_r - 9'h1;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      // one-cycle answer for own range only
      if (own && !mute) begin
        done_o <= 1'b1;
        done_oe <= 1'b1;
        ad_o <= hit ? mem_r[addr_r[1:0]] : 32'hDEAD5566;
      end
    end
    if (reset) begin
      pend_r <= 1'b0;
      done_o <= 1'b0;
      done_oe <= 1'b0;
      ad_o <= 32'h5A5A5A5A;
    end
  end
endmodule

//--- verif/main_bus_slave_port_test.sv
// self-checking bench for the shared-bus master against a slave model
`timescale 1ns/1ps
module main_bus_slave_port_test import mb_pkg::*;;
  logic clk, reset, req_valid, req_write, req_pcie, req_ready, rsp_valid, rsp_timeout;
  logic bus_enable, ad_oe, ale, rd, wr, strobe_oe, done_in, s_done, s_done_oe, mute;
  logic [31:0] req_addr, req_wdata, rsp_rdata, timeout_count, ad_in, ad_out, s_ad;
  logic [8:0] lat;
  int failures, checks, n_ale, n_rd, n_wr, b_ale, b_rd, b_wr;
  bus_master dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
    .req_pcie(req_pcie), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout),
    .bus_enable(bus_enable), .timeout_count(timeout_count), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .ale(ale), .rd(rd), .wr(wr), .strobe_oe(strobe_oe), .done_in(done_in));
  mb_slave_model model_u (.clk(clk), .reset(reset), .ad_in(ad_in), .ale(ale), .rd(rd),
    .wr(wr), .lat(lat), .mute(mute), .ad_o(s_ad), .done_o(s_done), .done_oe(s_done_oe));
  // wire resolution; done has a pull-down
  assign ad_in = ad_oe ? ad_out : s_ad;
  assign done_in = s_done_oe ? s_done : 1'b0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // free-running strobe counters; each transfer snapshots them at its start
  always @(posedge clk) begin
    n_ale <= n_ale + int'(ale === 1'b1);
    n_rd <= n_rd + int'(rd === 1'b1);
    n_wr <= n_wr + int'(wr === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one host request, held until taken, then wait for its answer
  task automatic xfer(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    b_ale = n_ale;
    b_rd = n_rd;
    b_wr = n_wr;
    req_write = w;
    req_pcie = p;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      failures++;
      $display("[ERR] %0t request not taken", $time);
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      failures++;
      $display("[ERR] %0t no answer", $time);
    end
  endtask
  task automatic t_disabled();
    bus_enable = 1'b0;
    xfer(1'b0, 1'b1, 32'h00000002, 32'h0);
    check(rsp_rdata, 32'h12345678);
    check(32'(n_ale - b_ale + n_rd - b_rd), 32'h0);
    xfer(1'b1, 1'b0, 32'h00000002, 32'h11111111);
    check(32'(n_ale - b_ale + n_rd - b_rd + n_wr - b_wr), 32'h0);
    check({31'h0, strobe_oe}, 32'h0);
  endtask
  task automatic t_wr_rd();
    bus_enable = 1'b1;
    lat = 9'h3;
    xfer(1'b1, 1'b0, 32'h00000002, 32'hA5A5F00F);
    check({31'h0, rsp_timeout}, 32'h0);
    check(32'((n_ale - b_ale) * 16 + n_wr - b_wr), 32'h11);
    xfer(1'b0, 1'b0, 32'h00000002, 32'h0);
    check(rsp_rdata, 32'hA5A5F00F);
    check(32'((n_ale - b_ale) * 16 + n_rd - b_rd), 32'h1);
  endtask
  task automatic t_unmapped();
    lat = 9'h0;
    xfer(1'b0, 1'b1, 32'h00000100, 32'h0);
    check(rsp_rdata, 32'hDEAD5566);
    lat = 9'h0FA;
    xfer(1'b0, 1'b1, 32'h00000002, 32'h0);
    check({rsp_timeout, rsp_rdata[30:0]}, 32'h25A5F00F);
  endtask
  task automatic t_timeouts();
    lat = 9'h2;
    xfer(1'b0, 1'b0, 32'h10000000, 32'h0);
    check(rsp_rdata, 32'hDEADDEAD);
    check({31'h0, rsp_timeout}, 32'h1);
    check(timeout_count, 32'h1);
    xfer(1'b0, 1'b1, 32'h10000004, 32'h0);
    check(rsp_rdata, 32'hABCDABCD);
    mute = 1'b1;
    xfer(1'b1, 1'b0, 32'h00000001, 32'h77);
    check({31'h0, rsp_timeout}, 32'h1);
    check(timeout_count, 32'h1);
    mute = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_pcie = 1'b0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    bus_enable = 1'b0;
    lat = 9'h0;
    mute = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    check(timeout_count, 32'h0);
    t_disabled();
    t_wr_rd();
    t_unmapped();
    t_timeouts();
    finish_test();
  end
endmodule
